// *** rtl/scp_pkg.sv ***
package scp_pkg;

  // word layout on the serial link
  localparam int WORD_BITS   = 24;
  localparam int CTRL_BITS   = 2;
  localparam int CTRL_LSB    = 0;
  localparam int NUM_LATCHES = 4;
  localparam int RB_BITS     = 16;

  // values after reset or power-down
  localparam logic [WORD_BITS-1:0]   WORD_RST  = 24'h000000;
  localparam logic [RB_BITS-1:0]     RB_RST    = 16'h0000;
  localparam logic [NUM_LATCHES-1:0] LATCH_RST = 4'h0;

  // system clock
  localparam int CLK_PERIOD_NS = 25;

  // least pin timings, rounded up to whole system clock cycles
  localparam int SCLK_HIGH_MIN_NS   = 25;
  localparam int SCLK_HIGH_MIN_CYC  = (SCLK_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_LOW_MIN_NS    = 25;
  localparam int SCLK_LOW_MIN_CYC   = (SCLK_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_MIN_NS      = 20;
  localparam int STROBE_MIN_CYC     = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // host pacing; each covers the least timing above and the device synchronisers
  localparam int SCLK_HALF_CYC   = 3;
  localparam int STROBE_HOLD_CYC = 4;
  localparam int GAP_CYC         = 4;
  localparam int RB_LEAD_EDGES   = 2;
  localparam int TMR_W           = 4;

  // host sequencer states
  typedef enum logic [4:0] {
    SCP_IDLE   = 5'b00001,
    SCP_LOW    = 5'b00010,
    SCP_HIGH   = 5'b00100,
    SCP_STROBE = 5'b01000,
    SCP_GAP    = 5'b10000
  } scp_host_state_type;

endpackage

// *** rtl/scp_if.sv ***
`timescale 1ns/100ps
interface scp_if;

  // power and framing from the host
  logic chip_en;
  logic word_load_strobe;
  // serial clock and data
  logic sclk;
  logic serial_word_in;
  logic serial_readback_out;

  // documented device end
  modport dev (
    input  chip_en,
    input  word_load_strobe,
    input  sclk,
    input  serial_word_in,
    output serial_readback_out
  );

  // microcontroller end
  modport host (
    output chip_en,
    output word_load_strobe,
    output sclk,
    output serial_word_in,
    input  serial_readback_out
  );

endinterface

// *** rtl/scp_device.sv ***
`timescale 1ns/100ps
module scp_device #(
  parameter int RB_W = scp_pkg::RB_BITS
) (
  // system clock and reset
  input  wire logic                                              clk,
  input  wire logic                                              nrst,
  // serial link, clocked by the host's serial clock
  scp_if.dev                                                     link,
  // readback source, system clock domain
  input  wire logic [RB_W-1:0]                                   readback_word,
  // programmed latches
  output logic      [scp_pkg::NUM_LATCHES-1:0][scp_pkg::WORD_BITS-1:0] latch_word,
  output logic      [scp_pkg::NUM_LATCHES-1:0]                   latch_valid,
  output logic      [scp_pkg::NUM_LATCHES-1:0]                   latch_load,
  // power state
  output logic                                                   powered_down
);
  import scp_pkg::*;

  localparam int CW = $clog2(RB_W + 1);
  localparam logic [CW-1:0] RB_LAST = CW'(RB_W);

  // link domain state
  logic [WORD_BITS-1:0] shift_reg;
  logic                 lnk_stb_s1_reg;
  logic                 lnk_stb_s2_reg;
  logic [CW-1:0]        rb_cnt_reg;
  logic                 rb_out_reg;

  // system domain state
  logic                                   ce_s1_reg;
  logic                                   ce_s2_reg;
  logic                                   stb_s1_reg;
  logic                                   stb_s2_reg;
  logic                                   stb_s3_reg;
  logic [RB_W-1:0]                        rb_hold_reg;
  logic [NUM_LATCHES-1:0][WORD_BITS-1:0]  latch_reg;
  logic [NUM_LATCHES-1:0]                 valid_reg;
  logic [NUM_LATCHES-1:0]                 load_reg;
  logic                                   pd_reg;
  logic                                   stb_rise;
  logic [CTRL_BITS-1:0]                   target_sel;
  logic [NUM_LATCHES-1:0]                 load_hit;

  // -------- link clock domain --------

  // chip enable rises only while the serial clock is parked, so the
  // release of this clear needs no synchroniser on the serial clock
  // shift register; chip enable low acts as its clear, so no serial
  // clock edge is needed to discard a half-shifted word
  always_ff @(posedge link.sclk or negedge link.chip_en) begin
    if (!link.chip_en) begin
      shift_reg <= WORD_RST;
    end else begin
      // oldest bit falls off the top, so only the last word stays
      shift_reg <= {shift_reg[WORD_BITS-2:0], link.serial_word_in};
    end
  end

  // strobe level seen by the serial clock, for readback framing
  always_ff @(posedge link.sclk or negedge link.chip_en) begin
    if (!link.chip_en) begin
      lnk_stb_s1_reg <= 1'b0;
      lnk_stb_s2_reg <= 1'b0;
    end else begin
      lnk_stb_s1_reg <= link.word_load_strobe;
      lnk_stb_s2_reg <= lnk_stb_s1_reg;
    end
  end

  // readback bit counter; two lead edges pass before the first bit because
  // the strobe is synchronised onto the serial clock first
  always_ff @(posedge link.sclk or negedge link.chip_en) begin
    if (!link.chip_en) begin
      rb_cnt_reg <= '0;
    end else if (!lnk_stb_s2_reg) begin
      rb_cnt_reg <= '0;
    end else if (rb_cnt_reg < RB_LAST) begin
      rb_cnt_reg <= rb_cnt_reg + 1'b1;
    end
  end

  // readback output, msb first; the hold word is frozen while the strobe
  // is high, so reading it here is safe
  always_ff @(posedge link.sclk or negedge link.chip_en) begin
    if (!link.chip_en) begin
      rb_out_reg <= 1'b0;
    end else if (lnk_stb_s2_reg && rb_cnt_reg < RB_LAST) begin
      rb_out_reg <= rb_hold_reg[RB_W - 1 - int'(rb_cnt_reg)];
    end else begin
      rb_out_reg <= 1'b0; // extra clocks read zero
    end
  end

  assign link.serial_readback_out = rb_out_reg;

  // -------- system clock domain --------

  // chip enable and strobe are pins here and pass two flip-flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ce_s1_reg <= 1'b0;
      ce_s2_reg <= 1'b0;
    end else begin
      ce_s1_reg <= link.chip_en;
      ce_s2_reg <= ce_s1_reg;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stb_s1_reg <= 1'b0;
      stb_s2_reg <= 1'b0;
      stb_s3_reg <= 1'b0;
    end else begin
      stb_s1_reg <= link.word_load_strobe;
      stb_s2_reg <= stb_s1_reg;
      stb_s3_reg <= stb_s2_reg;
    end
  end

  // rising edge of the synchronised strobe, only while powered
  assign stb_rise = stb_s2_reg & ~stb_s3_reg & ce_s2_reg;

  // shift register is quasi-static here: the host stops the serial
  // clock around the strobe edge, so the word is stable when copied
  assign target_sel = shift_reg[CTRL_LSB +: CTRL_BITS];

  // readback word tracks the source while the strobe is low and
  // freezes while it is high, so the link side sees a stable word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rb_hold_reg <= RB_RST;
    end else if (!ce_s2_reg) begin
      rb_hold_reg <= RB_RST;
    end else if (!stb_s2_reg) begin
      rb_hold_reg <= readback_word;
    end
  end

  // one latch per control code; contents, valid flag and load pulse
  // each have a process of their own
  generate
    for (genvar i = 0; i < NUM_LATCHES; i++) begin : g_latch
      // this latch is the one the control bits name
      assign load_hit[i] = stb_rise && (target_sel == CTRL_BITS'(i));

      // contents; power-down discards every programmed value
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          latch_reg[i] <= WORD_RST;
        end else if (!ce_s2_reg) begin
          latch_reg[i] <= WORD_RST;
        end else if (load_hit[i]) begin
          latch_reg[i] <= shift_reg;
        end
      end

      // written since chip enable rose
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          valid_reg[i] <= 1'b0;
        end else if (!ce_s2_reg) begin
          valid_reg[i] <= 1'b0;
        end else if (load_hit[i]) begin
          valid_reg[i] <= 1'b1;
        end
      end

      // one-cycle pulse per load; stb_rise already needs chip enable
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          load_reg[i] <= 1'b0;
        end else begin
          load_reg[i] <= load_hit[i];
        end
      end
    end
  endgenerate

  // power-down flag follows the synchronised chip enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pd_reg <= 1'b1;
    end else begin
      pd_reg <= ~ce_s2_reg;
    end
  end

  // outputs straight from flip-flops
  assign latch_word   = latch_reg;
  assign latch_valid  = valid_reg;
  assign latch_load   = load_reg;
  assign powered_down = pd_reg;

endmodule

// *** rtl/scp_host.sv ***
`timescale 1ns/100ps
module scp_host #(
  parameter int RB_W = scp_pkg::RB_BITS
) (
  // system clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // serial link; this end makes the serial clock
  scp_if.host                                link,
  // power control
  input  wire logic                          ce_on,
  // command request
  input  wire logic                          cmd_valid,
  input  wire logic                          cmd_read,
  input  wire logic [scp_pkg::WORD_BITS-1:0] cmd_word,
  output logic                               cmd_ready,
  // readback answer
  output logic      [RB_W-1:0]               rd_data,
  output logic                               rd_valid,
  // all four latches written since chip enable rose
  output logic                               cfg_complete
);
  import scp_pkg::*;

  localparam int CW = $clog2(RB_W + RB_LEAD_EDGES + WORD_BITS + 1);
  localparam logic [CW-1:0] WR_EDGES = CW'(WORD_BITS);
  localparam logic [CW-1:0] RB_EDGES = CW'(RB_W + RB_LEAD_EDGES);
  localparam logic [CW-1:0] RB_FIRST = CW'(RB_LEAD_EDGES + 1);

  scp_host_state_type    state_reg;
  logic [TMR_W-1:0]      tmr_reg;
  logic [CW-1:0]         cnt_reg;
  logic [WORD_BITS-1:0]  word_reg;
  logic                  rd_mode_reg;
  logic                  rb_phase_reg;
  logic                  ce_reg;
  logic                  sclk_reg;
  logic                  serial_word_in_reg;
  logic                  stb_reg;
  logic                  ready_reg;
  logic                  rb_s1_reg;
  logic                  rb_s2_reg;
  logic [RB_W-1:0]       rd_shift_reg;
  logic [RB_W-1:0]       rd_data_reg;
  logic                  rd_valid_reg;
  logic [NUM_LATCHES-1:0] written_reg;
  logic                  cfg_reg;
  logic                  tmr_done;
  logic [CW-1:0]         edges;

  assign tmr_done = (tmr_reg == '0);
  assign edges    = rb_phase_reg ? RB_EDGES : WR_EDGES;

  // readback pin passes two flip-flops before use
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rb_s1_reg <= 1'b0;
      rb_s2_reg <= 1'b0;
    end else begin
      rb_s1_reg <= link.serial_readback_out;
      rb_s2_reg <= rb_s1_reg;
    end
  end

  // chip enable follows the user level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ce_reg <= 1'b0;
    end else begin
      ce_reg <= ce_on;
    end
  end

  // sequencer; serial clock is divided down from clk by the half timer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= SCP_IDLE;
      tmr_reg      <= '0;
      cnt_reg      <= '0;
      word_reg     <= WORD_RST;
      rd_mode_reg  <= 1'b0;
      rb_phase_reg <= 1'b0;
      sclk_reg     <= 1'b0;
      serial_word_in_reg    <= 1'b0;
      stb_reg      <= 1'b0;
      rd_shift_reg <= RB_RST;
    end else if (!ce_reg) begin
      // a powered-down device forgets everything, so abort the frame
      state_reg    <= SCP_IDLE;
      sclk_reg     <= 1'b0;
      serial_word_in_reg    <= 1'b0;
      stb_reg      <= 1'b0;
      rb_phase_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        SCP_IDLE: begin
          if (cmd_valid && ready_reg) begin
            word_reg    <= cmd_word;
            rd_mode_reg <= cmd_read;
            cnt_reg     <= '0;
            serial_word_in_reg   <= cmd_word[WORD_BITS-1];
            tmr_reg     <= TMR_W'(SCLK_HALF_CYC - 1);
            state_reg   <= SCP_LOW;
          end
        end
        SCP_LOW: begin
          if (tmr_done) begin
            if (rb_phase_reg && cnt_reg >= RB_FIRST) begin
              rd_shift_reg <= {rd_shift_reg[RB_W-2:0], rb_s2_reg};
            end
            if (cnt_reg == edges && rb_phase_reg) begin
              stb_reg      <= 1'b0;
              rb_phase_reg <= 1'b0;
              tmr_reg      <= TMR_W'(GAP_CYC - 1);
              state_reg    <= SCP_GAP;
            end else if (cnt_reg == edges) begin
              stb_reg   <= 1'b1;
              tmr_reg   <= TMR_W'(STROBE_HOLD_CYC - 1);
              state_reg <= SCP_STROBE;
            end else begin
              sclk_reg  <= 1'b1;
              cnt_reg   <= cnt_reg + 1'b1;
              tmr_reg   <= TMR_W'(SCLK_HALF_CYC - 1);
              state_reg <= SCP_HIGH;
            end
          end else begin
            tmr_reg <= tmr_reg - 1'b1;
          end
        end
        SCP_HIGH: begin
          if (tmr_done) begin
            sclk_reg  <= 1'b0;
            // next bit, msb first; zero while clocking readback
            serial_word_in_reg <= (!rb_phase_reg && cnt_reg < WR_EDGES) ?
                         word_reg[WORD_BITS - 1 - int'(cnt_reg)] : 1'b0;
            tmr_reg   <= TMR_W'(SCLK_HALF_CYC - 1);
            state_reg <= SCP_LOW;
          end else begin
            tmr_reg <= tmr_reg - 1'b1;
          end
        end
        SCP_STROBE: begin
          if (!tmr_done) begin
            tmr_reg <= tmr_reg - 1'b1;
          end else if (rd_mode_reg) begin
            // strobe stays high while the readback bits are clocked
            rb_phase_reg <= 1'b1;
            cnt_reg      <= '0;
            tmr_reg      <= TMR_W'(SCLK_HALF_CYC - 1);
            state_reg    <= SCP_LOW;
          end else begin
            stb_reg   <= 1'b0;
            tmr_reg   <= TMR_W'(GAP_CYC - 1);
            state_reg <= SCP_GAP;
          end
        end
        SCP_GAP: begin
          if (tmr_done) begin
            state_reg <= SCP_IDLE;
          end else begin
            tmr_reg <= tmr_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // ready and readback answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ready_reg    <= 1'b0;
      rd_data_reg  <= RB_RST;
      rd_valid_reg <= 1'b0;
    end else begin
      ready_reg    <= ce_reg && state_reg == SCP_IDLE && !(cmd_valid && ready_reg);
      rd_valid_reg <= 1'b0;
      if (ce_reg && state_reg == SCP_LOW && tmr_done && rb_phase_reg && cnt_reg == edges) begin
        // the last bit is taken at this very edge, so fold it in here
        rd_data_reg  <= {rd_shift_reg[RB_W-2:0], rb_s2_reg};
        rd_valid_reg <= 1'b1;
      end
    end
  end

  // configuration is only trusted once every latch is rewritten
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      written_reg <= LATCH_RST;
      cfg_reg     <= 1'b0;
    end else if (!ce_reg) begin
      written_reg <= LATCH_RST;
      cfg_reg     <= 1'b0;
    end else begin
      if (state_reg == SCP_LOW && tmr_done && !rb_phase_reg && cnt_reg == WR_EDGES) begin
        written_reg[word_reg[CTRL_LSB +: CTRL_BITS]] <= 1'b1;
      end
      cfg_reg <= &written_reg;
    end
  end

  assign link.chip_en          = ce_reg;
  assign link.sclk             = sclk_reg;
  assign link.serial_word_in   = serial_word_in_reg;
  assign link.word_load_strobe = stb_reg;
  assign cmd_ready             = ready_reg;
  assign rd_data               = rd_data_reg;
  assign rd_valid              = rd_valid_reg;
  assign cfg_complete          = cfg_reg;

endmodule

// *** test/scp_asserts.sv ***
`timescale 1ns/100ps
module scp_asserts (
  // system clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link lines as seen on the wire
  input wire logic chip_en,
  input wire logic word_load_strobe,
  input wire logic sclk,
  input wire logic serial_word_in,
  input wire logic serial_readback_out
);
  import scp_pkg::*;

  logic       sclk_reg;
  logic [5:0] word_cnt_reg;
  logic [5:0] rb_cnt_reg;

  // serial clock one cycle late, so its rise shows in the clk domain
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) sclk_reg <= 1'b0;
    else sclk_reg <= sclk;

  // rises since the last strobe; power-down drops a half-shifted word
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) word_cnt_reg <= 6'h00;
    else if (word_load_strobe || !chip_en) word_cnt_reg <= 6'h00;
    else if (sclk && !sclk_reg) word_cnt_reg <= word_cnt_reg + 6'h01;

  // rises while the strobe is held up for readback
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) rb_cnt_reg <= 6'h00;
    else if (!word_load_strobe) rb_cnt_reg <= 6'h00;
    else if (sclk && !sclk_reg) rb_cnt_reg <= rb_cnt_reg + 6'h01;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // phases made by the host divider
  sequence s_high_phase;
    sclk [*3] ##1 !sclk;
  endsequence
  sequence s_low_phase;
    !sclk [*3];
  endsequence
  sequence s_strobe_hold;
    word_load_strobe [*4];
  endsequence

  a_sclk_high_len: assert property ($rose(sclk) |-> s_high_phase)
    else $error("serial clock high phase has the wrong length");
  a_sclk_low_len: assert property ($fell(sclk) |-> s_low_phase)
    else $error("serial clock low phase too short");
  a_data_stable: assert property (sclk |-> $stable(serial_word_in))
    else $error("serial data moved while the serial clock was high");
  a_strobe_width: assert property ($rose(word_load_strobe) |-> s_strobe_hold)
    else $error("load strobe too short");
  a_strobe_quiet: assert property ($rose(word_load_strobe) |-> s_low_phase)
    else $error("serial clock ran while the strobe rose");
  a_word_length: assert property ($rose(word_load_strobe) |-> word_cnt_reg == 6'(WORD_BITS))
    else $error("strobe rose after a word of the wrong length");
  a_readback_len: assert property ($fell(word_load_strobe) |->
    rb_cnt_reg == 6'h00 || rb_cnt_reg == 6'(RB_BITS + RB_LEAD_EDGES))
    else $error("wrong number of readback clocks");
  a_power_quiet: assert property (!chip_en && !$past(chip_en) |->
    !sclk && !word_load_strobe && !serial_readback_out)
    else $error("link active while powered down");
  a_readback_edge: assert property ($changed(serial_readback_out) |->
    $rose(sclk) || $fell(chip_en))
    else $error("readback output moved without a serial clock rise");
endmodule

// *** test/tb_serial_config_port.sv ***
`timescale 1ns/100ps
module tb_serial_config_port;
  import scp_pkg::*;

  // host side
  logic                                  clk;
  logic                                  nrst;
  logic                                  ce_on;
  logic                                  cmd_valid;
  logic                                  cmd_read;
  logic [WORD_BITS-1:0]                  cmd_word;
  logic                                  cmd_ready;
  logic [RB_BITS-1:0]                    rd_data;
  logic                                  rd_valid;
  logic                                  cfg_complete;
  // device side
  logic [RB_BITS-1:0]                    readback_word;
  logic [NUM_LATCHES-1:0][WORD_BITS-1:0] latch_word;
  logic [NUM_LATCHES-1:0]                latch_valid;
  logic [NUM_LATCHES-1:0]                latch_load;
  logic                                  powered_down;
  // bookkeeping
  int                                    n_fail;
  int                                    checks_done;
  int                                    load_cnt [NUM_LATCHES];
  int                                    exp_load [NUM_LATCHES];
  logic [WORD_BITS-1:0]                  exp_word [NUM_LATCHES];
  // low two bits of each word equal the latch index
  localparam logic [WORD_BITS-1:0] WORDS [NUM_LATCHES] = '{24'h80f0f0, 24'h3c5a01,
                                                           24'hf00ff2, 24'h12345b};

  scp_if scp_if_i ();

  scp_host #(.RB_W(RB_BITS)) scp_host_i (.clk(clk), .nrst(nrst), .link(scp_if_i),
    .ce_on(ce_on), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_word(cmd_word),
    .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .cfg_complete(cfg_complete));

  scp_device #(.RB_W(RB_BITS)) scp_device_i (.clk(clk), .nrst(nrst), .link(scp_if_i),
    .readback_word(readback_word), .latch_word(latch_word), .latch_valid(latch_valid),
    .latch_load(latch_load), .powered_down(powered_down));

  scp_asserts scp_asserts_i (.clk(clk), .nrst(nrst), .chip_en(scp_if_i.chip_en),
    .word_load_strobe(scp_if_i.word_load_strobe), .sclk(scp_if_i.sclk),
    .serial_word_in(scp_if_i.serial_word_in),
    .serial_readback_out(scp_if_i.serial_readback_out));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // count load pulses per latch; a stray load shows up here
  always @(posedge clk)
    for (int i = 0; i < NUM_LATCHES; i++)
      if (latch_load[i] === 1'b1) load_cnt[i]++;

  task automatic check(input logic [WORD_BITS-1:0] seen, input logic [WORD_BITS-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  // inputs always move 1 ns after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // bounded wait for the host to be idle
  task automatic wait_ready();
    int i;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 1000) begin
      tick(1);
      i++;
    end
    check(24'(cmd_ready), 24'h000001);
  endtask

  // one command, held until taken, then waited out
  task automatic send(input logic rd, input logic [WORD_BITS-1:0] w);
    int i;
    wait_ready();
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_word = w;
    tick(1);
    cmd_valid = 1'b0;
    tick(2);
    i = 0;
    while (rd && rd_valid !== 1'b1 && i < 1000) begin
      tick(1);
      i++;
    end
    if (rd) check(24'(rd_valid), 24'h000001);
    else wait_ready();
    exp_word[w[1:0]] = w;
    exp_load[w[1:0]]++;
  endtask

  task automatic check_latches(input logic [NUM_LATCHES-1:0] valid);
    for (int i = 0; i < NUM_LATCHES; i++) begin
      check(latch_word[i], exp_word[i]);
      check(24'(load_cnt[i]), 24'(exp_load[i]));
    end
    check(24'(latch_valid), 24'(valid));
  endtask

  // reset state with chip enable low, then power up
  task automatic t_power_up();
    check(24'(powered_down), 24'h000001);
    check(24'(cmd_ready), 24'h000000);
    check_latches(4'h0);
    ce_on = 1'b1;
    wait_ready();
    tick(4);
    check(24'(powered_down), 24'h000000);
  endtask

  // all four latches back to back, highest index first
  task automatic t_write_all();
    for (int i = NUM_LATCHES - 1; i >= 0; i--) begin
      check(24'(cfg_complete), 24'h000000);
      send(1'b0, WORDS[i]);
    end
    check_latches(4'hf);
    check(24'(cfg_complete), 24'h000001);
    send(1'b0, 24'h0aa5a5);
    check_latches(4'hf);
  endtask

  // two readbacks, each also reloading latch 2
  task automatic t_readback();
    logic [RB_BITS-1:0] v;
    for (int i = 0; i < 2; i++) begin
      v = i ? 16'h4c72 : 16'hb38d;
      readback_word = v;
      send(1'b1, {v, 8'h56});
      check(24'(rd_data), 24'(v));
    end
    check_latches(4'hf);
    // 18 readback clocks then a fresh word: only the last 24 bits load
    send(1'b0, 24'h6b1e03);
    check_latches(4'hf);
  endtask

  // power-down wipes everything; host must rewrite every latch
  task automatic t_power_down();
    ce_on = 1'b0;
    tick(6);
    exp_word = '{default: '0};
    check(24'(powered_down), 24'h000001);
    check_latches(4'h0);
    check(24'(cfg_complete), 24'h000000);
    ce_on = 1'b1;
    send(1'b0, WORDS[0]);
    check_latches(4'h1);
    check(24'(cfg_complete), 24'h000000);
    for (int i = 1; i < NUM_LATCHES; i++) send(1'b0, WORDS[i]);
    check_latches(4'hf);
    check(24'(cfg_complete), 24'h000001);
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    nrst = 1'b0;
    ce_on = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_word = '0;
    readback_word = '0;
    exp_word = '{default: '0};
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    tick(2);
    t_power_up();
    t_write_all();
    t_readback();
    t_power_down();
    print_verdict();
  end

  // watchdog, far beyond the few thousand cycles the run needs
  initial begin
    #(CLK_PERIOD_NS * 20000);
    n_fail++;
    print_verdict();
  end
endmodule
